// [design/het_pkg.sv]
// constants for the hopping-encoder transmit session controller
// assumes a single 125 MHz sys_clk that stands in for the on-chip oscillator
package het_pkg;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 125000;

  // figures in their own units
  localparam int unsigned DEBOUNCE_DELAY_MS       = 10;   // plain default
  localparam int unsigned POWER_UP_TO_TX_DELAY_MS = 30;   // plain default
  localparam int unsigned TIMEOUT_BASE_MS         = 800;  // 0.8 s
  localparam int unsigned SEED_DELAY_BASE_MS      = 800;  // 0.8 s
  localparam int unsigned LAMP_BASE_MS            = 50;
  localparam int unsigned ELEMENT_BASE_US         = 100;
  localparam int unsigned GAP_BASE_US             = 6400; // 6.4 ms

  // cycle counts derived from the figures
  localparam logic [31:0] DEBOUNCE_DELAY_CYC = 32'(DEBOUNCE_DELAY_MS * CLK_KHZ);
  localparam logic [31:0] POWER_UP_CYC       = 32'(POWER_UP_TO_TX_DELAY_MS * CLK_KHZ);
  localparam logic [31:0] TIMEOUT_BASE_CYC   = 32'(TIMEOUT_BASE_MS * CLK_KHZ);
  localparam logic [31:0] SEED_BASE_CYC      = 32'(SEED_DELAY_BASE_MS * CLK_KHZ);
  localparam logic [31:0] LAMP_BASE_CYC      = 32'(LAMP_BASE_MS * CLK_KHZ);
  localparam logic [31:0] ELEMENT_BASE_CYC   = 32'(ELEMENT_BASE_US * CLK_KHZ / 1000);
  localparam logic [31:0] GAP_BASE_CYC       = 32'(GAP_BASE_US * CLK_KHZ / 1000);

  // ----------------------------------------------------------------
  // option byte layouts
  // ----------------------------------------------------------------
  // format byte
  localparam int unsigned FMT_LSB   = 2;
  localparam int unsigned HDR_BIT   = 4;
  localparam int unsigned XSER_BIT  = 5;
  localparam int unsigned QUEN_BIT  = 6;
  localparam int unsigned STEN_BIT  = 7;
  // seed and timing byte
  localparam int unsigned SDLM_BIT  = 0;
  localparam int unsigned SDMD_BIT  = 1;
  localparam int unsigned SDTM_LSB  = 2;
  localparam int unsigned BSEL_LSB  = 4;
  localparam int unsigned GSEL_LSB  = 6;
  // lamp byte
  localparam int unsigned BLINK_BIT = 6;
  localparam int unsigned LAMP_BIT  = 7;
  // device byte
  localparam int unsigned MTX_LSB   = 0;
  localparam int unsigned TIMEOUT_CHOICE_LSB  = 4;

  // header lengths in basic elements
  localparam logic [3:0] HDR_SHORT = 4'h4;
  localparam logic [3:0] HDR_LONG  = 4'hA;
  localparam logic [3:0] WORDS_MAX = 4'hF;

  // session states
  typedef enum logic [1:0] {ST_SLEEP, ST_DEBOUNCE, ST_POWERUP, ST_TX} het_state_t;

endpackage

// [design/het_session.sv]
// session controller of a button-driven code-hopping remote encoder
// assumes buttons and options are synchronous to sys_clk and that the
// word serializer answers each word_start with one word_done pulse
//
// How it works
// - sleep until button, start regulator, debounce
// - latch options with code to pick format
// - words begin after power-up delay, repeat while held
// - two-bit field picks 0.8/3.2/12.8/25.6 s
// - time-out ends transmission and sleeps
// - new press aborts word, restarts time-out
// - after release finish minimum words 1/2/4/8
// - time-out beats unfinished minimum words
// - corrupted counter write: repair, do not increment
// - secret stored options never leave the block
// - wide options MSB first, right-justified
// - select low uses first encoder set
// - header length 4 or 10 elements
// - fixed part 28 or 32 serial bits
// - queue info and start/stop pulse enables
// - lamp low-battery blink and on-time
// - limited-seed and seed-mode bits
// - seed delay none/0.8/1.6/3.2 s
// - basic element 100/200/400/800 us
// - guard time 2 elements/6.4/51.2/102.4 ms
// - select high uses second encoder set
// - encrypted part computed once per press
module het_session #(
  parameter logic [31:0] DEBOUNCE_CYC = het_pkg::DEBOUNCE_DELAY_CYC,
  parameter logic [31:0] POWERUP_CYC  = het_pkg::POWER_UP_CYC,
  parameter logic [31:0] TIMEOUT_CYC  = het_pkg::TIMEOUT_BASE_CYC,
  parameter logic [31:0] SEED_CYC     = het_pkg::SEED_BASE_CYC,
  parameter logic [31:0] LAMP_CYC     = het_pkg::LAMP_BASE_CYC,
  parameter logic [31:0] ELEMENT_CYC  = het_pkg::ELEMENT_BASE_CYC,
  parameter logic [31:0] GAP_CYC      = het_pkg::GAP_BASE_CYC
) (
  input  wire logic        sys_clk,            // system clock
  input  wire logic        rst,                // sync reset, high
  input  wire logic [5:0]  btn,                // button inputs
  input  wire logic        enc_sel,            // encoder set select
  input  wire logic [7:0]  fmt_opt1,           // format byte, set 1
  input  wire logic [7:0]  fmt_opt2,           // format byte, set 2
  input  wire logic [7:0]  seed_opt1,          // seed/timing byte, set 1
  input  wire logic [7:0]  seed_opt2,          // seed/timing byte, set 2
  input  wire logic [7:0]  lamp_opt1,          // lamp byte, set 1
  input  wire logic [7:0]  lamp_opt2,          // lamp byte, set 2
  input  wire logic [7:0]  dev_opt,            // device byte
  input  wire logic [31:0] serial1,            // serial bytes, set 1
  input  wire logic [31:0] serial2,            // serial bytes, set 2
  input  wire logic        counter_bad,        // last counter write bad
  input  wire logic        word_done,          // serializer word end
  output logic             regulator_on,       // step-up regulator run
  output logic             radio_enable_out,   // rf stage enable
  output logic             asleep,             // low-power state
  output logic             word_start,         // begin a code word
  output logic             word_abort,         // drop word in progress
  output logic             hop_load,           // compute encrypted part
  output logic             count_incr,         // advance counter
  output logic             count_repair,       // restore and repair
  output logic [5:0]       btn_code,           // latched buttons
  output logic [31:0]      fixed_part,         // fixed portion
  output logic [1:0]       line_format_field,  // modulation
  output logic [3:0]       header_len,         // header elements
  output logic             queue_info_enable,  // queue bits on
  output logic             edge_pulse_enable,  // start/stop pulses on
  output logic             lowbatt_blink_bit,  // blink on low battery
  output logic [31:0]      lamp_on_cyc,        // lamp on-time
  output logic             limited_seed_bit,   // limited seed
  output logic             seed_behaviour_bit, // production seed mode
  output logic [31:0]      seed_delay_cyc,     // delay before seed words
  output logic [31:0]      element_cyc,        // basic element length
  output logic [31:0]      gap_cyc,            // guard time
  output logic [31:0]      timeout_cyc,        // session time-out
  output logic [3:0]       min_word_count      // minimum words
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    het_pkg::het_state_t st;
    logic [31:0] cnt;
    logic [31:0] tmo;
    logic [3:0]  words;
    logic        busy;
    logic        reg_on;
    logic        rf_en;
    logic        asleep;
    logic        wstart;
    logic        wabort;
    logic        hload;
    logic        incr;
    logic        repair;
    logic [5:0]  code;
    logic [5:0]  btn_q;
    logic [31:0] fixed;
    logic [1:0]  fmt;
    logic [3:0]  hdr;
    logic        quen;
    logic        sten;
    logic        blink;
    logic [31:0] lamp;
    logic        sdlm;
    logic        sdmd;
    logic [31:0] sdly;
    logic [31:0] elem;
    logic [31:0] gap;
    logic [31:0] tlim;
    logic [3:0]  minw;
  } het_q_t;

  het_q_t q_ff;
  het_q_t nxt_q;
  logic   do_press;
  logic   go_sleep;
  logic   tmo_hit;
  logic   new_press;
  logic   wake_edge;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // encoder set choice: low picks set 1, high picks set 2
  function automatic logic [7:0] pick(input logic sel, input logic [7:0] a,
                                      input logic [7:0] b);
    pick = sel ? b : a;
  endfunction

  // four-bit function code, buttons or-ed together
  function automatic logic [3:0] func_code(input logic [5:0] b);
    func_code = 4'h0;
    if (b[0]) func_code = func_code | 4'h2;
    if (b[1]) func_code = func_code | 4'h4;
    if (b[2]) func_code = func_code | 4'h8;
    if (b[3]) func_code = func_code | 4'h1;
    if (b[4]) func_code = func_code | 4'hE;
    if (b[5]) func_code = func_code | 4'hD;
  endfunction

  // time-out multiplier as a shift: x1, x4, x16, x32
  function automatic logic [2:0] tmo_shift(input logic [1:0] f);
    case (f)
      2'h0:    tmo_shift = 3'h0;
      2'h1:    tmo_shift = 3'h2;
      2'h2:    tmo_shift = 3'h4;
      default: tmo_shift = 3'h5;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign tmo_hit   = (q_ff.tmo >= q_ff.tlim - 32'h0000_0001);
  assign new_press = |(btn & ~q_ff.code);
  // wake only on a rising button, so a stuck button stays asleep after a time-out
  assign wake_edge = |(btn & ~q_ff.btn_q);

  // session sequencing
  always_comb
  begin
    logic [7:0]  fo;
    logic [7:0]  so;
    logic [7:0]  lo;
    logic [31:0] sr;
    logic [1:0]  sd;
    fo = pick(enc_sel, fmt_opt1, fmt_opt2);
    so = pick(enc_sel, seed_opt1, seed_opt2);
    lo = pick(enc_sel, lamp_opt1, lamp_opt2);
    sr = enc_sel ? serial2 : serial1;
    sd = so[het_pkg::SDTM_LSB +: 2];
    nxt_q = q_ff;
    nxt_q.btn_q = btn;
    nxt_q.wstart = 1'h0;
    nxt_q.wabort = 1'h0;
    nxt_q.hload = 1'h0;
    nxt_q.incr = 1'h0;
    nxt_q.repair = 1'h0;
    do_press = 1'h0;
    go_sleep = 1'h0;
    case (q_ff.st)
      het_pkg::ST_SLEEP:
      begin
        if (wake_edge)
        begin
          nxt_q.st = het_pkg::ST_DEBOUNCE;
          nxt_q.cnt = 32'h0000_0000;
          nxt_q.reg_on = 1'h1;
          nxt_q.asleep = 1'h0;
        end
      end
      het_pkg::ST_DEBOUNCE:
      begin
        nxt_q.cnt = q_ff.cnt + 32'h0000_0001;
        if (q_ff.cnt >= DEBOUNCE_CYC - 32'h0000_0001)
        begin
          if (|btn)
          begin
            do_press = 1'h1;
            nxt_q.st = het_pkg::ST_POWERUP;
          end
          else
          begin
            go_sleep = 1'h1;
          end
        end
      end
      het_pkg::ST_POWERUP:
      begin
        nxt_q.cnt = q_ff.cnt + 32'h0000_0001;
        if (q_ff.cnt >= POWERUP_CYC - 32'h0000_0001)
        begin
          nxt_q.st = het_pkg::ST_TX;
          nxt_q.rf_en = 1'h1;
          nxt_q.tmo = 32'h0000_0000;
          nxt_q.words = 4'h0;
          nxt_q.busy = 1'h0;
        end
      end
      default:
      begin
        nxt_q.tmo = q_ff.tmo + 32'h0000_0001;
        if (tmo_hit)
        begin
          nxt_q.wabort = q_ff.busy;
          go_sleep = 1'h1;
        end
        else if (new_press)
        begin
          nxt_q.wabort = q_ff.busy;
          nxt_q.busy = 1'h0;
          nxt_q.tmo = 32'h0000_0000;
          nxt_q.words = 4'h0;
          do_press = 1'h1;
        end
        else if (q_ff.busy && word_done)
        begin
          nxt_q.busy = 1'h0;
          if (q_ff.words != het_pkg::WORDS_MAX)
            nxt_q.words = q_ff.words + 4'h1;
          if (btn == 6'h00 && q_ff.words >= q_ff.minw - 4'h1)
            go_sleep = 1'h1;
        end
        else if (!q_ff.busy)
        begin
          nxt_q.wstart = 1'h1;
          nxt_q.busy = 1'h1;
        end
      end
    endcase
    // latch buttons, compute encrypted part once, decode options
    if (do_press)
    begin
      nxt_q.code = btn;
      nxt_q.hload = 1'h1;
      nxt_q.incr = !counter_bad;
      nxt_q.repair = counter_bad;
      nxt_q.fmt = fo[het_pkg::FMT_LSB +: 2];
      nxt_q.hdr = fo[het_pkg::HDR_BIT] ? het_pkg::HDR_LONG : het_pkg::HDR_SHORT;
      // serial bytes arrive msb first; 28-bit form keeps low bits
      nxt_q.fixed = fo[het_pkg::XSER_BIT] ? sr : {sr[27:0], func_code(btn)};
      nxt_q.quen = fo[het_pkg::QUEN_BIT];
      nxt_q.sten = fo[het_pkg::STEN_BIT];
      nxt_q.blink = lo[het_pkg::BLINK_BIT];
      nxt_q.lamp = LAMP_CYC << lo[het_pkg::LAMP_BIT];
      nxt_q.sdlm = so[het_pkg::SDLM_BIT];
      nxt_q.sdmd = so[het_pkg::SDMD_BIT];
      nxt_q.sdly = (sd == 2'h0) ? 32'h0000_0000 : SEED_CYC << (sd - 2'h1);
      nxt_q.elem = ELEMENT_CYC << so[het_pkg::BSEL_LSB +: 2];
      case (so[het_pkg::GSEL_LSB +: 2])
        2'h0:    nxt_q.gap = nxt_q.elem << 1;
        2'h1:    nxt_q.gap = GAP_CYC;
        2'h2:    nxt_q.gap = GAP_CYC << 3;
        default: nxt_q.gap = GAP_CYC << 4;
      endcase
      nxt_q.tlim = TIMEOUT_CYC << tmo_shift(dev_opt[het_pkg::TIMEOUT_CHOICE_LSB +: 2]);
      nxt_q.minw = 4'h1 << dev_opt[het_pkg::MTX_LSB +: 2];
    end
    if (go_sleep)
    begin
      nxt_q.st = het_pkg::ST_SLEEP;
      nxt_q.rf_en = 1'h0;
      nxt_q.reg_on = 1'h0;
      nxt_q.asleep = 1'h1;
      nxt_q.busy = 1'h0;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q_ff <= '0;
      q_ff.asleep <= 1'h1;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // keys and seeds have no path here; only decoded fields leave
  assign regulator_on       = q_ff.reg_on;
  assign radio_enable_out   = q_ff.rf_en;
  assign asleep             = q_ff.asleep;
  assign word_start         = q_ff.wstart;
  assign word_abort         = q_ff.wabort;
  assign hop_load           = q_ff.hload;
  assign count_incr         = q_ff.incr;
  assign count_repair       = q_ff.repair;
  assign btn_code           = q_ff.code;
  assign fixed_part         = q_ff.fixed;
  assign line_format_field  = q_ff.fmt;
  assign header_len         = q_ff.hdr;
  assign queue_info_enable  = q_ff.quen;
  assign edge_pulse_enable  = q_ff.sten;
  assign lowbatt_blink_bit  = q_ff.blink;
  assign lamp_on_cyc        = q_ff.lamp;
  assign limited_seed_bit   = q_ff.sdlm;
  assign seed_behaviour_bit = q_ff.sdmd;
  assign seed_delay_cyc     = q_ff.sdly;
  assign element_cyc        = q_ff.elem;
  assign gap_cyc            = q_ff.gap;
  assign timeout_cyc        = q_ff.tlim;
  assign min_word_count     = q_ff.minw;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_abort_restart;
    q_ff.tmo == 32'h0000_0000 ##1 q_ff.wstart;
  endsequence

  a_wake_regulator: assert property (q_ff.st == het_pkg::ST_SLEEP && wake_edge |=>
    q_ff.reg_on && !q_ff.asleep && !q_ff.hload)
    else $error("regulator not started on button");
  a_debounce_hold: assert property (q_ff.st == het_pkg::ST_DEBOUNCE &&
    q_ff.cnt < DEBOUNCE_CYC - 32'h0000_0001 |=> !q_ff.hload)
    else $error("button code latched before debounce");
  a_set_one: assert property (do_press && !enc_sel |=>
    q_ff.fmt == $past(fmt_opt1[het_pkg::FMT_LSB +: 2]))
    else $error("first encoder set not used");
  a_set_two: assert property (do_press && enc_sel |=>
    q_ff.quen == $past(fmt_opt2[het_pkg::QUEN_BIT]))
    else $error("second encoder set not used");
  a_tx_start: assert property ($rose(q_ff.rf_en) |->
    $past(q_ff.cnt) >= POWERUP_CYC - 32'h0000_0001 ##1 q_ff.wstart)
    else $error("words not started after power-up");
  a_timeout_sleep: assert property (q_ff.st == het_pkg::ST_TX && tmo_hit |=>
    q_ff.asleep && !q_ff.rf_en && !q_ff.wstart)
    else $error("time-out did not end transmission");
  a_new_press: assert property (q_ff.st == het_pkg::ST_TX && !tmo_hit &&
    new_press && q_ff.busy |=> q_ff.wabort and s_abort_restart)
    else $error("new press did not abort and restart");
  a_min_words: assert property (q_ff.st == het_pkg::ST_TX && !tmo_hit &&
    !new_press && q_ff.busy && word_done && q_ff.words < q_ff.minw - 4'h1 &&
    q_ff.tmo + 32'h0000_0002 < q_ff.tlim |=> q_ff.rf_en ##1 q_ff.wstart)
    else $error("minimum words not completed");
  a_repair_only: assert property (do_press && counter_bad |=>
    q_ff.repair && !q_ff.incr)
    else $error("corrupted counter was incremented");
  a_hop_steady: assert property (q_ff.st == het_pkg::ST_TX && !new_press |=>
    !q_ff.hload && $stable(q_ff.code))
    else $error("encrypted part recomputed without press");
  a_header_len: assert property (do_press |=>
    q_ff.hdr == ($past(enc_sel ? fmt_opt2[het_pkg::HDR_BIT] : fmt_opt1[het_pkg::HDR_BIT])
    ? het_pkg::HDR_LONG : het_pkg::HDR_SHORT))
    else $error("header length mismatch");

endmodule

// [verification/het_far_model.sv]
// serializer and rf stage stand-in for the session controller
// assumes word_start, word_abort and asleep come from het_session
module het_far_model (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       rst,        // sync reset, high
  input  wire logic       word_start, // begin a code word
  input  wire logic       word_abort, // drop the open word
  input  wire logic       asleep,     // session asleep
  input  wire logic [7:0] word_len,   // cycles per word, 2 or more
  output logic            word_done   // one-cycle word end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;                // cycles left in open word

  // one word at a time; abort or sleep drops it without a done pulse
  always_ff @(posedge sys_clk)
  begin
    word_done <= 1'b0;
    if (rst)
      left_ff <= 8'h00;
    else if (word_start)
      left_ff <= word_len;
    else if (word_abort || asleep)
      left_ff <= 8'h00;
    else if (left_ff == 8'h01)
    begin
      word_done <= 1'b1;
      left_ff   <= 8'h00;
    end
    else if (left_ff != 8'h00)
      left_ff <= left_ff - 8'h01;
  end
endmodule

// [verification/tb_hopping_encoder_tx_session.sv]
// self-checking bench of het_session with a serializer stand-in
// assumes shortened counts so a full run stays well under 100k cycles
module tb_hopping_encoder_tx_session;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] DB = 32'h0000_0004, PU = 32'h0000_000C, TM = 32'h0000_00C8;
  localparam logic [31:0] SD = 32'h0000_0008, LM = 32'h0000_0005;
  localparam logic [31:0] EL = 32'h0000_0003, GP = 32'h0000_0007;
  logic        sys_clk, rst, enc_sel, counter_bad, word_done, regulator_on, radio_enable_out;
  logic        asleep, word_start, word_abort, hop_load, count_incr, count_repair;
  logic        queue_info_enable, edge_pulse_enable, lowbatt_blink_bit, limited_seed_bit;
  logic        seed_behaviour_bit, radio_q;
  logic [5:0]  btn, btn_code;
  logic [7:0]  fmt_opt1, fmt_opt2, seed_opt1, seed_opt2, lamp_opt1, lamp_opt2, dev_opt, wlen;
  logic [31:0] serial1, serial2, fixed_part, lamp_on_cyc, seed_delay_cyc, element_cyc;
  logic [31:0] gap_cyc, timeout_cyc, lfsr;
  logic [1:0]  line_format_field;
  logic [3:0]  header_len, min_word_count;
  int          fails, checks_done, words, el, hops;

  het_session #(.DEBOUNCE_CYC(DB), .POWERUP_CYC(PU), .TIMEOUT_CYC(TM), .SEED_CYC(SD),
    .LAMP_CYC(LM), .ELEMENT_CYC(EL), .GAP_CYC(GP)) het_session_i (.sys_clk, .rst, .btn,
    .enc_sel, .fmt_opt1, .fmt_opt2, .seed_opt1, .seed_opt2, .lamp_opt1, .lamp_opt2, .dev_opt,
    .serial1, .serial2, .counter_bad, .word_done, .regulator_on, .radio_enable_out, .asleep,
    .word_start, .word_abort, .hop_load, .count_incr, .count_repair, .btn_code, .fixed_part,
    .line_format_field, .header_len, .queue_info_enable, .edge_pulse_enable,
    .lowbatt_blink_bit, .lamp_on_cyc, .limited_seed_bit, .seed_behaviour_bit,
    .seed_delay_cyc, .element_cyc, .gap_cyc, .timeout_cyc, .min_word_count);
  het_far_model het_far_model_i (.sys_clk, .rst, .word_start, .word_abort, .asleep,
    .word_len(wlen), .word_done);

  // ------------------------------------------------------------
  // clock, watchdog and session monitor
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    complete_run();
  end
  // words and cycles since transmission start or the latest press
  always @(posedge sys_clk)
  begin
    radio_q <= radio_enable_out;
    if (hop_load === 1'b1)
      hops <= hops + 1;
    if ((radio_enable_out && !radio_q) || hop_load)
    begin
      words <= 0;
      el    <= 0;
    end
    else
    begin
      el <= el + 1;
      if (word_done && radio_enable_out)
        words <= words + 1;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // bounded wait: 0 hop_load, 1 asleep, 2 word_start
  task automatic wait_sig(input int w, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (!(w == 0 ? hop_load === 1'b1 : w == 1 ? asleep === 1'b1 : word_start === 1'b1)
               && n < lim);
    cmp(32'(n < lim), 32'h0000_0001);
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // one session: press, decode check, then release, repress or hold
  // ------------------------------------------------------------
  task automatic session(input int i);
    logic [31:0] r, q, tm_e;
    logic [7:0]  f, s, l, d;
    logic [5:0]  code;
    logic [3:0]  fc;
    logic        sel, hold, rep;
    int          h0;
    r = rnd();
    q = rnd();
    f = r[7:0];
    f[3:2] = i[1:0];
    s = r[15:8];
    s[3:2] = i[2:1];
    s[5:4] = i[1:0];
    s[7:6] = 2'(i + 1);
    l = r[23:16];
    d = r[31:24];
    d[5:4] = i[1:0];
    d[1:0] = i[2:1];
    sel = q[16];
    hold = (i % 3 == 0);
    rep = (i % 3 == 1);
    code = (q[4:0] == 5'h00) ? 6'h01 : {1'b0, q[4:0]};
    fc = {4{code[0]}} & 4'h2 | {4{code[1]}} & 4'h4 | {4{code[2]}} & 4'h8 | {4{code[3]}} & 4'h1
       | {4{code[4]}} & 4'hE | {4{code[5]}} & 4'hD;
    tm_e = TM << (d[5:4] == 2'h3 ? 5 : 2 * d[5:4]);
    h0 = hops;
    // the unselected set carries inverted bytes so a wrong pick shows
    @(posedge sys_clk);
    fmt_opt1 <= sel ? ~f : f;
    fmt_opt2 <= sel ? f : ~f;
    seed_opt1 <= sel ? ~s : s;
    seed_opt2 <= sel ? s : ~s;
    lamp_opt1 <= sel ? ~l : l;
    lamp_opt2 <= sel ? l : ~l;
    serial1 <= sel ? ~r : r;
    serial2 <= sel ? r : ~r;
    dev_opt <= d;
    enc_sel <= sel;
    counter_bad <= q[8];
    wlen <= 8'd20 + 8'(q[13:8]);
    btn <= code;
    wait_sig(0, 2 * DB + 8);
    cmp(32'({regulator_on, count_incr, count_repair}), q[8] ? 32'h5 : 32'h6);
    @(posedge sys_clk);
    #1;
    cmp(32'(btn_code), 32'(code));
    cmp(32'(line_format_field), 32'(f[3:2]));
    cmp(32'(header_len), f[4] ? 32'h0000_000A : 32'h0000_0004);
    cmp(fixed_part, f[5] ? r : {r[27:0], fc});
    cmp(32'({queue_info_enable, edge_pulse_enable}), 32'({f[6], f[7]}));
    cmp(32'({lowbatt_blink_bit, limited_seed_bit, seed_behaviour_bit}),
        32'({l[6], s[0], s[1]}));
    cmp(lamp_on_cyc, LM << l[7]);
    cmp(seed_delay_cyc, s[3:2] == 2'h0 ? 32'h0 : SD << (s[3:2] - 2'h1));
    cmp(element_cyc, EL << s[5:4]);
    cmp(gap_cyc, s[7:6] == 2'h0 ? (2 * EL) << s[5:4]
                 : GP << (s[7:6] == 2'h1 ? 0 : s[7:6] + 1));
    cmp(timeout_cyc, tm_e);
    cmp(32'(min_word_count), 32'h1 << d[1:0]);
    if (rep)
    begin
      wait_sig(2, 2 * PU + 8);
      cmp(32'(radio_enable_out), 32'h1);
      @(posedge sys_clk);
      btn <= code | 6'h20;
      wait_sig(0, 8);
      cmp(32'(word_abort), 32'h1);
      @(posedge sys_clk);
      #1;
      cmp(32'(btn_code), 32'(code | 6'h20));
    end
    if (!hold)
    begin
      @(posedge sys_clk);
      btn <= 6'h00;
    end
    wait_sig(1, 8000);
    if (hold)
      cmp(32'(el + 3 >= tm_e && el <= tm_e + 3), 32'h1);
    else
      cmp(32'(words == 1 << d[1:0] || (words < 1 << d[1:0] && el + 3 >= tm_e)), 32'h1);
    cmp(32'({regulator_on, radio_enable_out}), 32'h0);
    cmp(32'(hops - h0), rep ? 32'h2 : 32'h1);
    // a button still held after the time-out must not wake the block again
    repeat (2 * PU + 10) @(posedge sys_clk);
    #1;
    cmp(32'({asleep, regulator_on}), 32'h2);
    @(posedge sys_clk);
    btn <= 6'h00;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst, enc_sel, counter_bad, btn, dev_opt, wlen} = {3'b100, 6'h00, 8'h00, 8'h14};
    {fmt_opt1, fmt_opt2, seed_opt1, seed_opt2, lamp_opt1, lamp_opt2} = '0;
    {serial1, serial2} = '0;
    {fails, checks_done, words, el, hops} = '0;
    lfsr = 32'h0001_1821;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    cmp(32'({asleep, regulator_on, radio_enable_out, word_start, hop_load}), 32'h10);
    for (int i = 0; i < 8; i++)
      session(i);
    complete_run();
  end
endmodule
